// >>> src/uca_map.svh
// Constants of the UART configuration command interpreter: frame bytes,
// register numbers, reset values, host register offsets and timing counts.
// Assumes a 25 MHz clock; included by both ends and by the package user.
`ifndef UCA_MAP_SVH
`define UCA_MAP_SVH

// Frame and answer bytes
`define UCA_HDR          8'hff
`define UCA_SIZE_SHORT   8'h02
`define UCA_SIZE_LONG    8'h03
`define UCA_ESC          8'hfe
`define UCA_ACK          8'h06
`define UCA_NACK         8'h15
`define UCA_HI_OFFSET    8'h80

// Device register numbers and reset values
`define UCA_REG_HOP_NV   8'h00
`define UCA_REG_CRC      8'h40
`define UCA_REG_HOP      8'h4b
`define UCA_RST_HOP      8'h00
`define UCA_RST_CRC      8'h00
`define UCA_HOP_MAX      8'h05
`define UCA_HOP_SEQS     6
`define UCA_HOP_STEPS    26

// Timing: non-volatile write time and host answer wait
`define UCA_CLK_MHZ      25
`define UCA_NV_WRITE_US  16000
`define UCA_NV_WRITE_CYC (`UCA_NV_WRITE_US * `UCA_CLK_MHZ)
`define UCA_RSP_WAIT_US  20000
`define UCA_RSP_WAIT_CYC (`UCA_RSP_WAIT_US * `UCA_CLK_MHZ)
`define UCA_MAX_TRIES    3

// Host APB register offsets and field positions
`define UCA_APB_CMD      12'h000
`define UCA_APB_STATUS   12'h004
`define UCA_APB_RESULT   12'h008
`define UCA_CMD_READ_BIT 16
`define UCA_ST_BUSY      0
`define UCA_ST_DONE      1
`define UCA_ST_NACK      2
`define UCA_ST_FAIL      3

`endif

// >>> src/uca_pkg.sv
// Types shared by both ends of the configuration command link.
// Assumes uca_map.svh for all numeric constants.
package uca_pkg;
   typedef enum logic [2:0] {D_HDR, D_SIZE, D_B2, D_B3, D_B4, D_EXEC, D_NV, D_TX} uca_dev_st_t;
   typedef enum logic [1:0] {H_IDLE, H_SEND, H_WAIT} uca_host_st_t;
endpackage : uca_pkg

// >>> src/uca_link_if.sv
// Byte link between host controller and configuration interpreter.
// Both ends run on the same clock; each byte moves on valid and ready high.
`timescale 1ns/1ps
interface uca_link_if;
   logic       h2d_valid;
   logic [7:0] h2d_data;
   logic       h2d_ready;
   logic       d2h_valid;
   logic [7:0] d2h_data;
   logic       d2h_ready;
   modport dev  (input h2d_valid, input h2d_data, output h2d_ready,
                 output d2h_valid, output d2h_data, input d2h_ready);
   modport host (output h2d_valid, output h2d_data, input h2d_ready,
                 input d2h_valid, input d2h_data, output d2h_ready);
endinterface : uca_link_if

// >>> src/uca_dev.sv
// Configuration command interpreter: parses framed read and write commands,
// keeps hop select and CRC failure counter, answers ACK or NACK, and steps
// through the selected hop sequence. Assumes a single clock shared with the
// host end, and crc_fail / hop_step pulses from logic on that clock.
//
// Notes on behaviour
// - Write below 128: FF 02 reg value
// - Write 128 up: FF 03 reg FE value
// - Volatile write at once, non-volatile 16 ms
// - Successful write answered with ACK 06
// - Host resends command when no ACK; this host resends on silence only, a NACK ends the order
// - Bad register write gets NACK 15
// - Read is FF 02 FE reg
// - Read answer: ACK, register number, value
// - Read value goes out raw, unescaped
// - Unknown register read gets NACK 15
// - CRC counter counts failed packets
// - Writing zero clears the CRC counter
// - Hop select 0x4b, copy 0x00, 0-5
// - Hop sequence zero unless reconfigured
// - Step channels in selected sequence order
`timescale 1ns/1ps
`include "uca_map.svh"
module uca_dev
   import uca_pkg::*;
#(
   parameter int NV_WRITE_CYC = `UCA_NV_WRITE_CYC
) (
   input  wire logic       clk,
   input  wire logic       srst,
   input  wire logic       ce,
   uca_link_if.dev         link,
   input  wire logic       crc_fail,
   input  wire logic       hop_step,
   output logic [4:0]      rf_channel,
   output logic [7:0]      hop_sel,
   output logic            nv_busy
);
   // Hop sequences, one row per sequence, entries are channel numbers 0..31
   localparam logic [4:0] HOP_TAB [0:`UCA_HOP_SEQS-1][0:`UCA_HOP_STEPS-1] = '{
      '{5'd16, 5'd1, 5'd2, 5'd5, 5'd10, 5'd21, 5'd11, 5'd23, 5'd14, 5'd29, 5'd27, 5'd22, 5'd12,
        5'd24, 5'd17, 5'd3, 5'd7, 5'd15, 5'd31, 5'd30, 5'd28, 5'd25, 5'd19, 5'd6, 5'd13, 5'd26},
      '{5'd15, 5'd30, 5'd29, 5'd26, 5'd21, 5'd10, 5'd20, 5'd8, 5'd17, 5'd2, 5'd4, 5'd9, 5'd19,
        5'd7, 5'd14, 5'd28, 5'd24, 5'd16, 5'd0, 5'd1, 5'd3, 5'd6, 5'd12, 5'd25, 5'd18, 5'd5},
      '{5'd3, 5'd20, 5'd21, 5'd24, 5'd29, 5'd8, 5'd30, 5'd10, 5'd1, 5'd16, 5'd14, 5'd9, 5'd31,
        5'd11, 5'd4, 5'd22, 5'd26, 5'd2, 5'd18, 5'd17, 5'd15, 5'd12, 5'd6, 5'd25, 5'd0, 5'd13},
      '{5'd28, 5'd11, 5'd10, 5'd7, 5'd2, 5'd23, 5'd1, 5'd21, 5'd30, 5'd15, 5'd17, 5'd22, 5'd0,
        5'd20, 5'd27, 5'd9, 5'd5, 5'd29, 5'd13, 5'd14, 5'd16, 5'd19, 5'd25, 5'd6, 5'd31, 5'd18},
      '{5'd22, 5'd7, 5'd8, 5'd11, 5'd16, 5'd27, 5'd17, 5'd29, 5'd20, 5'd3, 5'd1, 5'd28, 5'd18,
        5'd30, 5'd23, 5'd9, 5'd13, 5'd21, 5'd5, 5'd4, 5'd2, 5'd31, 5'd25, 5'd12, 5'd19, 5'd0},
      '{5'd9, 5'd24, 5'd23, 5'd20, 5'd15, 5'd4, 5'd14, 5'd2, 5'd11, 5'd28, 5'd30, 5'd3, 5'd13,
        5'd1, 5'd8, 5'd22, 5'd18, 5'd10, 5'd26, 5'd27, 5'd29, 5'd0, 5'd6, 5'd19, 5'd12, 5'd31}
   };

   uca_dev_st_t state_q;
   logic        rdy_q;
   logic        rd_q;
   logic [7:0]  size_q;
   logic [7:0]  addr_q;
   logic [7:0]  val_q;
   logic [7:0]  tx_buf_q [0:2];
   logic [1:0]  tx_last_q;
   logic [1:0]  tx_idx_q;
   logic        tx_vld_q;
   logic [7:0]  tx_data_q;
   logic [31:0] nv_cnt_q;
   logic        commit_q;
   logic        nv_busy_q;
   logic [7:0]  hop_q;
   logic [7:0]  hop_nv_q;
   logic [7:0]  crc_q;
   logic [4:0]  step_q;
   logic [4:0]  chan_q;
   logic        take;
   logic        addr_ok;
   logic        val_ok;
   logic [7:0]  rd_val;

   assign take = ce & link.h2d_valid & rdy_q;

   // Register decode for the command being executed
   always_comb begin
      addr_ok = 1'b1;
      rd_val  = 8'h00;
      unique case (addr_q)
         `UCA_REG_HOP_NV: rd_val = hop_nv_q;
         `UCA_REG_HOP:    rd_val = hop_q;
         `UCA_REG_CRC:    rd_val = crc_q;
         default:         addr_ok = 1'b0;
      endcase
   end

   // Hop select only takes sequence numbers 0..5
   assign val_ok = (addr_q == `UCA_REG_CRC) || (val_q <= `UCA_HOP_MAX);

   // Frame parser, command execution and answer sender
   always_ff @(posedge clk) begin
      if (srst) begin
         state_q   <= D_HDR;
         rdy_q     <= 1'b0;
         rd_q      <= 1'b0;
         size_q    <= 8'h00;
         addr_q    <= 8'h00;
         val_q     <= 8'h00;
         tx_buf_q  <= '{8'h00, 8'h00, 8'h00};
         tx_last_q <= 2'd0;
         tx_idx_q  <= 2'd0;
         tx_vld_q  <= 1'b0;
         tx_data_q <= 8'h00;
         nv_cnt_q  <= 32'd0;
         commit_q  <= 1'b0;
         nv_busy_q <= 1'b0;
      end else if (ce) begin
         commit_q <= 1'b0;
         unique case (state_q)
            D_HDR: begin
               rdy_q <= 1'b1;
               if (take && link.h2d_data == `UCA_HDR) state_q <= D_SIZE;
            end
            D_SIZE: if (take) begin
               size_q  <= link.h2d_data;
               state_q <= (link.h2d_data == `UCA_SIZE_SHORT ||
                           link.h2d_data == `UCA_SIZE_LONG) ? D_B2 : D_HDR;
            end
            D_B2: if (take) begin
               // Escape right after a short size marks a read
               rd_q    <= (size_q == `UCA_SIZE_SHORT) && (link.h2d_data == `UCA_ESC);
               addr_q  <= link.h2d_data;
               state_q <= D_B3;
            end
            D_B3: if (take) begin
               if (rd_q) begin
                  addr_q  <= link.h2d_data;
                  rdy_q   <= 1'b0;
                  state_q <= D_EXEC;
               end else if (size_q == `UCA_SIZE_SHORT) begin
                  val_q   <= link.h2d_data;
                  rdy_q   <= 1'b0;
                  state_q <= D_EXEC;
               end else begin
                  state_q <= (link.h2d_data == `UCA_ESC) ? D_B4 : D_HDR;
               end
            end
            D_B4: if (take) begin
               val_q   <= link.h2d_data + `UCA_HI_OFFSET;
               rdy_q   <= 1'b0;
               state_q <= D_EXEC;
            end
            D_EXEC: begin
               tx_idx_q <= 2'd0;
               tx_vld_q <= 1'b1;
               if (!addr_ok || (!rd_q && !val_ok)) begin
                  tx_data_q <= `UCA_NACK;
                  tx_last_q <= 2'd0;
                  state_q   <= D_TX;
               end else if (rd_q) begin
                  tx_data_q <= `UCA_ACK;
                  tx_buf_q  <= '{`UCA_ACK, addr_q, rd_val};
                  tx_last_q <= 2'd2;
                  state_q   <= D_TX;
               end else if (addr_q == `UCA_REG_HOP_NV) begin
                  tx_vld_q <= 1'b0;
                  nv_cnt_q <= 32'd0;
                  nv_busy_q <= 1'b1;
                  state_q  <= D_NV;
               end else begin
                  commit_q  <= 1'b1;
                  tx_data_q <= `UCA_ACK;
                  tx_last_q <= 2'd0;
                  state_q   <= D_TX;
               end
            end
            D_NV: begin
               // Non-volatile store holds the answer back for its write time
               nv_cnt_q <= nv_cnt_q + 32'd1;
               if (nv_cnt_q == NV_WRITE_CYC - 1) begin
                  commit_q  <= 1'b1;
                  nv_busy_q <= 1'b0;
                  tx_vld_q  <= 1'b1;
                  tx_data_q <= `UCA_ACK;
                  tx_last_q <= 2'd0;
                  tx_idx_q  <= 2'd0;
                  state_q   <= D_TX;
               end
            end
            D_TX: if (link.d2h_ready) begin
               if (tx_idx_q == tx_last_q) begin
                  tx_vld_q <= 1'b0;
                  rdy_q    <= 1'b1;
                  state_q  <= D_HDR;
               end else begin
                  tx_data_q <= tx_buf_q[tx_idx_q + 2'd1];
                  tx_idx_q  <= tx_idx_q + 2'd1;
               end
            end
         endcase
      end
   end

   // Configuration registers; a CRC failure in the clearing cycle still counts
   always_ff @(posedge clk) begin
      if (srst) begin
         hop_q    <= `UCA_RST_HOP;
         hop_nv_q <= `UCA_RST_HOP;
         crc_q    <= `UCA_RST_CRC;
      end else if (ce) begin
         if (commit_q && addr_q == `UCA_REG_HOP) hop_q <= val_q;
         if (commit_q && addr_q == `UCA_REG_HOP_NV) hop_nv_q <= val_q;
         if (commit_q && addr_q == `UCA_REG_CRC) crc_q <= val_q + {7'd0, crc_fail};
         else if (crc_fail) crc_q <= crc_q + 8'd1;
      end
   end

   // Hop position: restarts when the sequence changes, steps on hop_step
   always_ff @(posedge clk) begin
      if (srst) begin
         step_q <= 5'd0;
         chan_q <= 5'd0;
      end else if (ce) begin
         if (commit_q && addr_q == `UCA_REG_HOP) step_q <= 5'd0;
         else if (hop_step) step_q <= (step_q == 5'(`UCA_HOP_STEPS - 1)) ? 5'd0 : step_q + 5'd1;
         chan_q <= HOP_TAB[hop_q[2:0]][step_q];
      end
   end

   assign link.h2d_ready = rdy_q;
   assign link.d2h_valid = tx_vld_q;
   assign link.d2h_data  = tx_data_q;
   assign rf_channel     = chan_q;
   assign hop_sel        = hop_q;
   assign nv_busy        = nv_busy_q;
endmodule : uca_dev

// >>> src/uca_host.sv
// Host controller: takes register read and write orders over APB, frames
// them for the configuration link, retries on silence, reports the answer.
// Assumes the same clock as the device end; APB master on that clock too.
`timescale 1ns/1ps
`include "uca_map.svh"
module uca_host
   import uca_pkg::*;
#(
   parameter int RSP_WAIT_CYC = `UCA_RSP_WAIT_CYC,
   parameter int MAX_TRIES    = `UCA_MAX_TRIES
) (
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic        ce,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   uca_link_if.host         link
);
   uca_host_st_t state_q;
   logic [7:0]   fr_q [0:4];
   logic [2:0]   fr_last_q;
   logic [2:0]   fr_idx_q;
   logic         rd_q;
   logic         busy_q, done_q, nack_q, fail_q;
   logic [7:0]   res_addr_q, res_val_q;
   logic [1:0]   rx_idx_q;
   logic [31:0]  wait_q;
   logic [3:0]   tries_q;
   logic         tx_vld_q;
   logic [7:0]   tx_data_q;
   logic         rx_rdy_q;
   logic [31:0]  prdata_q;
   logic         pready_q, pslverr_q;
   logic         acc, wr_cmd, clr_done, finish, mapped;
   logic [7:0]   c_addr, c_val;

   assign acc      = psel & penable & pready_q;
   assign mapped   = paddr == `UCA_APB_CMD || paddr == `UCA_APB_STATUS ||
                     paddr == `UCA_APB_RESULT;
   assign wr_cmd   = acc & pwrite & (paddr == `UCA_APB_CMD) & ~busy_q;
   assign clr_done = acc & pwrite & (paddr == `UCA_APB_STATUS) & pwdata[`UCA_ST_DONE];
   assign c_addr   = pwdata[7:0];
   assign c_val    = pwdata[15:8];

   // APB slave: one wait state, read data registered on the same edge as pready
   always_ff @(posedge clk) begin
      if (srst) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0;
      end else if (ce) begin
         pready_q  <= psel & penable & ~pready_q;
         pslverr_q <= psel & penable & ~pready_q & ~mapped;
         if (psel & penable & ~pready_q) begin
            unique case (paddr)
               `UCA_APB_STATUS: prdata_q <= {28'h0, fail_q, nack_q, done_q, busy_q};
               `UCA_APB_RESULT: prdata_q <= {16'h0, res_val_q, res_addr_q};
               default:         prdata_q <= 32'h0;
            endcase
         end
      end
   end

   // Answer parser: ACK or NACK, then address and value for reads
   assign finish = (state_q == H_WAIT) && link.d2h_valid && rx_rdy_q &&
                   (link.d2h_data == `UCA_NACK || !rd_q || rx_idx_q == 2'd2) &&
                   (rx_idx_q != 2'd0 || link.d2h_data == `UCA_NACK ||
                    link.d2h_data == `UCA_ACK);

   // Command framing, sending, waiting and retrying
   always_ff @(posedge clk) begin
      if (srst) begin
         state_q    <= H_IDLE;
         fr_q       <= '{8'h0, 8'h0, 8'h0, 8'h0, 8'h0};
         fr_last_q  <= 3'd0;
         fr_idx_q   <= 3'd0;
         rd_q       <= 1'b0;
         busy_q     <= 1'b0;
         done_q     <= 1'b0;
         nack_q     <= 1'b0;
         fail_q     <= 1'b0;
         res_addr_q <= 8'h0;
         res_val_q  <= 8'h0;
         rx_idx_q   <= 2'd0;
         wait_q     <= 32'd0;
         tries_q    <= 4'd0;
         tx_vld_q   <= 1'b0;
         tx_data_q  <= 8'h0;
         rx_rdy_q   <= 1'b0;
      end else if (ce) begin
         rx_rdy_q <= 1'b1;
         if (clr_done && !finish) done_q <= 1'b0;
         unique case (state_q)
            H_IDLE: if (wr_cmd) begin
               rd_q     <= pwdata[`UCA_CMD_READ_BIT];
               busy_q   <= 1'b1;
               nack_q   <= 1'b0;
               fail_q   <= 1'b0;
               tries_q  <= 4'd1;
               fr_idx_q <= 3'd0;
               tx_vld_q <= 1'b1;
               tx_data_q <= `UCA_HDR;
               state_q  <= H_SEND;
               if (pwdata[`UCA_CMD_READ_BIT]) begin
                  fr_q      <= '{`UCA_HDR, `UCA_SIZE_SHORT, `UCA_ESC, c_addr, 8'h0};
                  fr_last_q <= 3'd3;
               end else if (c_val < `UCA_HI_OFFSET) begin
                  fr_q      <= '{`UCA_HDR, `UCA_SIZE_SHORT, c_addr, c_val, 8'h0};
                  fr_last_q <= 3'd3;
               end else begin
                  fr_q      <= '{`UCA_HDR, `UCA_SIZE_LONG, c_addr, `UCA_ESC,
                                 c_val - `UCA_HI_OFFSET};
                  fr_last_q <= 3'd4;
               end
            end
            H_SEND: if (link.h2d_ready) begin
               if (fr_idx_q == fr_last_q) begin
                  tx_vld_q <= 1'b0;
                  rx_idx_q <= 2'd0;
                  wait_q   <= 32'd0;
                  state_q  <= H_WAIT;
               end else begin
                  tx_data_q <= fr_q[fr_idx_q + 3'd1];
                  fr_idx_q  <= fr_idx_q + 3'd1;
               end
            end
            H_WAIT: begin
               wait_q <= wait_q + 32'd1;
               if (finish) begin
                  busy_q  <= 1'b0;
                  done_q  <= 1'b1;
                  nack_q  <= (link.d2h_data == `UCA_NACK) && rx_idx_q == 2'd0;
                  if (rd_q && rx_idx_q == 2'd2) res_val_q <= link.d2h_data;
                  state_q <= H_IDLE;
               end else if (link.d2h_valid && rx_rdy_q && rx_idx_q != 2'd0) begin
                  res_addr_q <= link.d2h_data;
                  rx_idx_q   <= 2'd2;
               end else if (link.d2h_valid && rx_rdy_q && link.d2h_data == `UCA_ACK) begin
                  rx_idx_q <= 2'd1;
               end else if (wait_q == RSP_WAIT_CYC - 1) begin
                  if (tries_q == 4'(MAX_TRIES)) begin
                     busy_q  <= 1'b0;
                     done_q  <= 1'b1;
                     fail_q  <= 1'b1;
                     state_q <= H_IDLE;
                  end else begin
                     tries_q   <= tries_q + 4'd1;
                     fr_idx_q  <= 3'd0;
                     tx_vld_q  <= 1'b1;
                     tx_data_q <= `UCA_HDR;
                     state_q   <= H_SEND;
                  end
               end
            end
            default: state_q <= H_IDLE;
         endcase
      end
   end

   assign link.h2d_valid = tx_vld_q;
   assign link.h2d_data  = tx_data_q;
   assign link.d2h_ready = rx_rdy_q;
   assign prdata         = prdata_q;
   assign pready         = pready_q;
   assign pslverr        = pslverr_q;
endmodule : uca_host

// >>> verif/uca_link_chk.sv
// Checker for the byte link between host and device ends.
// Assumes ce held high and both ends on clk; device NV write time of 20 cycles.
`timescale 1ns/1ps
`include "uca_map.svh"
module uca_link_chk (
   input wire logic       clk,
   input wire logic       srst,
   input wire logic       h2d_valid,
   input wire logic [7:0] h2d_data,
   input wire logic       h2d_ready,
   input wire logic       d2h_valid,
   input wire logic [7:0] d2h_data,
   input wire logic       d2h_ready
);
   logic [2:0] cnt_q;
   logic [1:0] idx_q;
   logic [7:0] size_q, b2_q, reg_q, rg, vl;
   logic       rd_q, acc, e2, e3, is_rd, good, fin_nv, fin_f, last;
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   // Decode the frame that ends with the byte taken at this edge
   assign acc    = h2d_valid && h2d_ready;
   assign e2     = acc && cnt_q == 3'd3 && size_q == `UCA_SIZE_SHORT;
   assign e3     = acc && cnt_q == 3'd4 && size_q == `UCA_SIZE_LONG;
   assign is_rd  = e2 && b2_q == `UCA_ESC;
   assign rg     = is_rd ? h2d_data : b2_q;
   assign vl     = e3 ? h2d_data + `UCA_HI_OFFSET : h2d_data;
   assign good   = (rg == `UCA_REG_HOP_NV || rg == `UCA_REG_CRC || rg == `UCA_REG_HOP)
                   && (is_rd || rg == `UCA_REG_CRC || vl <= `UCA_HOP_MAX);
   assign fin_nv = e2 && good && !is_rd && rg == `UCA_REG_HOP_NV;
   assign fin_f  = (e2 || e3) && !fin_nv;
   assign last   = d2h_valid && d2h_ready && (!rd_q || idx_q == 2'd2);
   // Byte position inside the frame; bad size or missing escape resyncs
   always_ff @(posedge clk) begin
      if (srst || e2 || e3) cnt_q <= 3'd0;
      else if (acc && cnt_q == 3'd0) cnt_q <= {2'b00, h2d_data == `UCA_HDR};
      else if (acc && cnt_q == 3'd1 && h2d_data != `UCA_SIZE_SHORT
               && h2d_data != `UCA_SIZE_LONG) cnt_q <= 3'd0;
      else if (acc && cnt_q == 3'd3 && h2d_data != `UCA_ESC) cnt_q <= 3'd0;
      else if (acc) cnt_q <= cnt_q + 3'd1;
   end
   // Size and second byte of the frame in flight
   always_ff @(posedge clk) begin
      if (acc && cnt_q == 3'd1) size_q <= h2d_data;
      if (acc && cnt_q == 3'd2) b2_q <= h2d_data;
   end
   // Answer byte count after each frame
   always_ff @(posedge clk) begin
      if (srst) rd_q <= 1'b0;
      else if (e2 || e3) rd_q <= good && is_rd;
      if (e2 || e3) reg_q <= rg;
      if (srst || e2 || e3) idx_q <= 2'd0;
      else if (d2h_valid && d2h_ready) idx_q <= idx_q + 2'd1;
   end
   AST_WR_ACK: assert property (fin_f && good && !is_rd |-> ##2 d2h_valid && d2h_data == `UCA_ACK)
      else $error("write not answered with ack");
   AST_BAD_NACK: assert property (fin_f && !good |-> ##2 d2h_valid && d2h_data == `UCA_NACK)
      else $error("bad register not answered with nack");
   AST_RD_ACK: assert property (fin_f && good && is_rd |-> ##2 d2h_valid && d2h_data == `UCA_ACK)
      else $error("read not answered with ack");
   AST_RD_ECHO: assert property (d2h_valid && rd_q && idx_q == 2'd1 |-> d2h_data == reg_q)
      else $error("read answer lacks register number");
   AST_NV_ACK: assert property (fin_nv |-> ##1 !d2h_valid [*8] ##[10:24] (d2h_valid && d2h_data == `UCA_ACK))
      else $error("non-volatile write ack out of time");
   AST_BUSY_REFUSE: assert property (d2h_valid |-> !h2d_ready)
      else $error("device takes bytes while answering");
   AST_READY_BACK: assert property (last |-> ##[1:3] h2d_ready)
      else $error("device not ready after answer");
   AST_ANS_HOLD: assert property (d2h_valid && !d2h_ready |=> d2h_valid && $stable(d2h_data))
      else $error("answer byte changed before taken");
   AST_REQ_HOLD: assert property (h2d_valid && !h2d_ready |=> h2d_valid && $stable(h2d_data))
      else $error("command byte changed before taken");
   AST_HDR_FIRST: assert property (h2d_valid && cnt_q == 3'd0 |-> h2d_data == `UCA_HDR)
      else $error("frame does not open with header");
   // Main scenarios reached
   cover property (fin_nv);
   cover property (e3 && good);
   cover property (last && rd_q);
   cover property (fin_f && !good);
endmodule : uca_link_chk

// >>> verif/uart_config_register_access_bench.sv
// Bench: host and device joined by one link, a second host facing a silent
// far end. Assumes the constants of uca_map.svh and a 25 MHz clock.
`timescale 1ns/1ps
`include "uca_map.svh"
module uart_config_register_access_bench;
   logic        clk, srst, ce, sel2, psel, penable, pwrite, crc_fail, hop_step, nv_seen, err_s;
   logic        pready, prdy1, prdy2, perr, perr1, perr2, nv_busy;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, prd1, prd2, seed, st, res, tmp;
   logic [4:0]  rf_channel;
   logic [7:0]  hop_sel, m_hop, m_nv, m_crc, r;
   logic [4:0]  tbl [4][6];
   int          error_cnt, n_compared, cyc, hdr2;
   uca_link_if link_a ();
   uca_link_if link_b ();
   // APB answer from whichever host is addressed
   assign prdata = sel2 ? prd2 : prd1;
   assign pready = sel2 ? prdy2 : prdy1;
   assign perr   = sel2 ? perr2 : perr1;
   // Silent far end of the second link: takes bytes, never answers
   assign link_b.h2d_ready = 1'b1;
   assign link_b.d2h_valid = 1'b0;
   assign link_b.d2h_data  = cyc[7:0];
   uca_dev #(.NV_WRITE_CYC(20)) i_uca_dev (.clk(clk), .srst(srst), .ce(ce), .link(link_a),
      .crc_fail(crc_fail), .hop_step(hop_step), .rf_channel(rf_channel), .hop_sel(hop_sel),
      .nv_busy(nv_busy));
   uca_host #(.RSP_WAIT_CYC(60), .MAX_TRIES(3)) i_uca_host (.clk(clk), .srst(srst), .ce(ce),
      .psel(psel && !sel2), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prd1), .pready(prdy1), .pslverr(perr1), .link(link_a));
   uca_host #(.RSP_WAIT_CYC(60), .MAX_TRIES(3)) i_uca_host_b (.clk(clk), .srst(srst), .ce(ce),
      .psel(psel && sel2), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prd2), .pready(prdy2), .pslverr(perr2), .link(link_b));
   uca_link_chk i_uca_link_chk (.clk(clk), .srst(srst), .h2d_valid(link_a.h2d_valid),
      .h2d_data(link_a.h2d_data), .h2d_ready(link_a.h2d_ready), .d2h_valid(link_a.d2h_valid),
      .d2h_data(link_a.d2h_data), .d2h_ready(link_a.d2h_ready));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // Cycle limit, busy watch and header count on the silent link
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (nv_busy === 1'b1) nv_seen <= 1'b1;
      if (link_b.h2d_valid && link_b.h2d_data == `UCA_HDR) hdr2 <= hdr2 + 1;
      if (cyc == 40000) begin
         error_cnt++;
         end_of_test();
      end
   end
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // One APB transfer; read data and error land in tmp and err_s
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      tmp = prdata;
      err_s = perr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // Issue an order, wait for done, fetch the result and clear done
   task automatic cmd(input logic rd, input logic [7:0] rg, input logic [7:0] val);
      int n;
      apb(1'b1, `UCA_APB_CMD, {15'h0000, rd, val, rg});
      n = 0;
      st = 32'h0;
      while (st[`UCA_ST_DONE] !== 1'b1 && n < 3000) begin
         apb(1'b0, `UCA_APB_STATUS, 32'h0);
         st = tmp;
         n++;
      end
      apb(1'b0, `UCA_APB_RESULT, 32'h0);
      res = tmp;
      apb(1'b1, `UCA_APB_STATUS, 32'h2);
   endtask : cmd
   // Order plus comparison against the register model
   task automatic op(input logic rd, input logic [7:0] rg, input logic [7:0] val);
      logic       bad;
      logic [7:0] cur;
      bad = !(rg == 8'h00 || rg == 8'h40 || rg == 8'h4b) || (!rd && rg != 8'h40 && val > 8'h05);
      cur = (rg == 8'h40) ? m_crc : (rg == 8'h4b) ? m_hop : m_nv;
      cmd(rd, rg, val);
      chk("nack", st[`UCA_ST_NACK], bad);
      chk("fail", st[`UCA_ST_FAIL], 1'b0);
      if (rd && !bad) chk("read", res[15:0], {cur, rg});
      if (!rd && !bad && rg == 8'h40) m_crc = val;
      if (!rd && !bad && rg == 8'h4b) m_hop = val;
      if (!rd && !bad && rg == 8'h00) m_nv = val;
      chk("hop_sel", hop_sel, m_hop);
   endtask : op
   task automatic end_of_test();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : end_of_test
   // Main sequence
   initial begin
      int n;
      {ce, sel2, psel, penable, pwrite, crc_fail, hop_step, nv_seen} = 8'h80;
      {paddr, pwdata} = 44'h0;
      {error_cnt, n_compared, cyc, hdr2} = 128'h0;
      {m_hop, m_nv, m_crc} = 24'h0;
      seed = 32'd75;
      srst = 1'b1;
      tbl = '{'{16, 15, 3, 28, 22, 9}, '{1, 30, 20, 11, 7, 24},
              '{2, 29, 21, 10, 8, 23}, '{5, 26, 24, 7, 11, 20}};
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      repeat (3) @(posedge clk);
      chk("channel", rf_channel, 5'd16);
      op(1'b1, 8'h4b, 8'h00);
      op(1'b1, 8'h00, 8'h00);
      op(1'b1, 8'h40, 8'h00);
      op(1'b0, 8'h40, 8'h83);
      op(1'b1, 8'h40, 8'h00);
      op(1'b0, 8'h40, 8'h00);
      op(1'b1, 8'h41, 8'h00);
      op(1'b0, 8'h4b, 8'h06);
      op(1'b0, 8'h7f, 8'h01);
      apb(1'b0, 12'h00c, 32'h0);
      chk("slverr", err_s, 1'b1);
      // Non-volatile copy takes its busy time
      nv_seen = 1'b0;
      op(1'b0, 8'h00, 8'h05);
      chk("nv_busy", nv_seen, 1'b1);
      op(1'b1, 8'h00, 8'h00);
      // Failed packets counted from a cleared counter
      n = xs() % 7 + 3;
      crc_fail <= 1'b1;
      repeat (n) @(posedge clk);
      crc_fail <= 1'b0;
      m_crc = m_crc + 8'(n);
      op(1'b1, 8'h40, 8'h00);
      // Every hop sequence, first steps and wrap after 26
      for (int s = 0; s < 6; s++) begin
         op(1'b0, 8'h4b, 8'(s));
         for (int k = 0; k < 27; k++) begin
            if (k < 4 || k == 26) chk("channel", rf_channel, tbl[k % 26][s]);
            @(posedge clk);
            hop_step <= 1'b1;
            @(posedge clk);
            hop_step <= 1'b0;
            repeat (2) @(posedge clk);
         end
      end
      // Random reads and writes, valid and invalid
      for (int i = 0; i < 24; i++) begin
         tmp = xs();
         r = (tmp[9:8] == 2'd0) ? 8'h00 : (tmp[9:8] == 2'd1) ? 8'h40 : (tmp[9:8] == 2'd2)
             ? 8'h4b : (tmp[23:16] & 8'h7f);
         op(tmp[10], r, tmp[11] ? tmp[7:0] : {5'h00, tmp[2:0]});
      end
      // Host facing silence retries then gives up
      sel2 <= 1'b1;
      cmd(1'b1, 8'h4b, 8'h00);
      chk("tries", hdr2, 32'd3);
      chk("fail", st[`UCA_ST_FAIL], 1'b1);
      end_of_test();
   end
endmodule : uart_config_register_access_bench
